// ==== setm_counter.sv ====
// one saturating error counter with threshold compare
`default_nettype none
module setm_counter
    import setm_pkg::*;
#(
    parameter int CNT_W = 10,
    parameter int THR_W = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // event and control
    input wire logic event_in,
    input wire logic clear,
    input wire logic enable,
    input wire logic [THR_W-1:0] threshold,
    // result
    output logic [CNT_W-1:0] count,
    output logic over
);
    // refuse widths the compare cannot serve, at elaboration
    if (THR_W > CNT_W || CNT_W < 1) begin : g_bad_param
        $error("setm_counter: counter narrower than threshold");
    end

    logic [CNT_W-1:0] cnt_q, cnt_d;

    // counter saturates so a flood cannot wrap back below the threshold
    always_comb begin
        cnt_d = cnt_q;
        if (event_in && cnt_q != {CNT_W{1'b1}}) begin
            cnt_d = CNT_W'(cnt_q + 1'b1);
        end else if (clear) begin
            cnt_d = '0;
        end
        if (clear && event_in) begin
            cnt_d = {{(CNT_W-1){1'b0}}, 1'b1}; // event in the clear cycle is kept
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    // strictly greater than, and only while enabled
    assign over = enable && (cnt_q > CNT_W'(threshold));
endmodule // setm_counter
`default_nettype wire

// ==== setm_monitor.sv ====
// scrub error threshold monitor: four counters, sticky status, failing access capture, interrupt
// Behaviour
// - A disabled threshold never raises status or interrupt for its error type.
// - An enabled type raises status, and interrupt if enabled, once its count exceeds the threshold.
// - The AHB uncorrectable threshold is eight bits wide, upper written bits ignored.
// - The AHB correctable threshold is ten bits wide, upper written bits ignored.
// - The scrub block-count threshold is eight bits wide, upper written bits ignored.
// - The scrub run-count threshold is ten bits wide, upper written bits ignored.
// - Each threshold has its own enable and all enables reset to disabled.
// - AHB status, scrub status and the failing AHB access capture are all readable.
// - Software clears status after reading it and the block then rearms for the next error.
// - The error interrupt has a software enable and fires only for enabled threshold conditions.
`include "setm_params.svh"
`default_nettype none
module setm_monitor
    import setm_pkg::*;
#(
    parameter int ADDR_W = `SETM_ADDR_W,
    parameter int CNT_W = `SETM_CNT_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // error events from the AHB side, one-cycle pulses
    input wire logic ahb_ce_evt,
    input wire logic ahb_ue_evt,
    input wire logic [ADDR_W-1:0] ahb_err_addr,
    input wire logic ahb_err_write,
    // error events from the scrubber, one-cycle pulses
    input wire logic scrub_run_evt,
    input wire logic scrub_blk_evt,
    // configuration written by software
    input wire logic [31:0] ue_thr_wr,
    input wire logic [31:0] ce_thr_wr,
    input wire logic [31:0] blk_thr_wr,
    input wire logic [31:0] run_thr_wr,
    input wire logic cfg_ahb_we,
    input wire logic cfg_scrub_we,
    input wire logic ce_en_wr,
    input wire logic ue_en_wr,
    input wire logic run_en_wr,
    input wire logic blk_en_wr,
    input wire logic irq_en_wr,
    input wire logic irq_en_we,
    // status clear strobes, one-cycle pulses
    input wire logic ahb_status_clr,
    input wire logic scrub_status_clr,
    // readable state
    output logic [ADDR_W-1:0] ahb_fail_addr,
    output logic ahb_fail_write,
    output logic ahb_fail_ue,
    output logic ahb_ce_status,
    output logic ahb_ue_status,
    output logic [CNT_W-1:0] ahb_ce_count,
    output logic [CNT_W-1:0] ahb_ue_count,
    output logic scrub_run_status,
    output logic scrub_blk_status,
    output logic [CNT_W-1:0] scrub_run_count,
    output logic [CNT_W-1:0] scrub_blk_count,
    output logic [3:0] thr_en,
    output logic irq_en,
    output logic [`SETM_UE_THR_W-1:0] ue_thr,
    output logic [`SETM_CE_THR_W-1:0] ce_thr,
    output logic [`SETM_BLK_THR_W-1:0] blk_thr,
    output logic [`SETM_RUN_THR_W-1:0] run_thr,
    // interrupt, level
    output logic err_irq
);
    // refuse widths the compare cannot serve, at elaboration
    if (CNT_W < `SETM_CE_THR_W || ADDR_W < 1) begin : g_bad_param
        $error("setm_monitor: counter narrower than threshold");
    end

    // configuration state
    logic [`SETM_UE_THR_W-1:0] ue_thr_q, ue_thr_d;
    logic [`SETM_CE_THR_W-1:0] ce_thr_q, ce_thr_d;
    logic [`SETM_BLK_THR_W-1:0] blk_thr_q, blk_thr_d;
    logic [`SETM_RUN_THR_W-1:0] run_thr_q, run_thr_d;
    logic [3:0] en_q, en_d;
    logic irq_en_q, irq_en_d;

    // only low bits of the written words are kept
    always_comb begin
        ue_thr_d = ue_thr_q;
        ce_thr_d = ce_thr_q;
        blk_thr_d = blk_thr_q;
        run_thr_d = run_thr_q;
        en_d = en_q;
        irq_en_d = irq_en_q;
        if (cfg_ahb_we) begin
            ue_thr_d = ue_thr_wr[`SETM_UE_THR_W-1:0];
            ce_thr_d = ce_thr_wr[`SETM_CE_THR_W-1:0];
            en_d[`SETM_IDX_CE] = ce_en_wr;
            en_d[`SETM_IDX_UE] = ue_en_wr;
        end
        if (cfg_scrub_we) begin
            blk_thr_d = blk_thr_wr[`SETM_BLK_THR_W-1:0];
            run_thr_d = run_thr_wr[`SETM_RUN_THR_W-1:0];
            en_d[`SETM_IDX_RUN] = run_en_wr;
            en_d[`SETM_IDX_BLK] = blk_en_wr;
        end
        if (irq_en_we) begin
            irq_en_d = irq_en_wr;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ue_thr_q <= '0;
            ce_thr_q <= '0;
            blk_thr_q <= '0;
            run_thr_q <= '0;
            en_q <= {4{`SETM_EN_RESET}};
            irq_en_q <= `SETM_EN_RESET;
        end else begin
            ue_thr_q <= ue_thr_d;
            ce_thr_q <= ce_thr_d;
            blk_thr_q <= blk_thr_d;
            run_thr_q <= run_thr_d;
            en_q <= en_d;
            irq_en_q <= irq_en_d;
        end
    end

    // per-type counters; index order ce, ue, run, blk
    logic [3:0] evt, clr, over;
    logic [CNT_W-1:0] cnt [4];
    logic [`SETM_CE_THR_W-1:0] thr_ext [4];

    assign evt = {scrub_blk_evt, scrub_run_evt, ahb_ue_evt, ahb_ce_evt};
    assign clr = {scrub_status_clr, scrub_status_clr, ahb_status_clr, ahb_status_clr};
    assign thr_ext[`SETM_IDX_CE] = ce_thr_q;
    assign thr_ext[`SETM_IDX_UE] = {2'h0, ue_thr_q};
    assign thr_ext[`SETM_IDX_RUN] = run_thr_q;
    assign thr_ext[`SETM_IDX_BLK] = {2'h0, blk_thr_q};

    for (genvar i = 0; i < 4; i++) begin : g_cnt
        setm_counter #(
            .CNT_W(CNT_W),
            .THR_W(`SETM_CE_THR_W)
        ) u_cnt (
            .mclk(mclk),
            .rstn(rstn),
            .event_in(evt[i]),
            .clear(clr[i]),
            .enable(en_q[i]),
            .threshold(thr_ext[i]),
            .count(cnt[i]),
            .over(over[i])
        );
    end

    // sticky status; the clear beats a standing crossing, an error in the clear cycle survives in the counter
    logic [3:0] st_q, st_d;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            st_d[k] = st_q[k];
            if (clr[k]) st_d[k] = 1'b0;
            if (over[k] && !clr[k]) st_d[k] = 1'b1;
            if (!en_q[k]) st_d[k] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // failing access capture: first AHB error after rearm is held
    setm_cap_state_type cap_q, cap_d;
    logic [ADDR_W-1:0] fa_q, fa_d;
    logic fw_q, fw_d, fu_q, fu_d;
    logic ahb_evt;
    assign ahb_evt = ahb_ce_evt || ahb_ue_evt;

    always_comb begin
        cap_d = cap_q;
        fa_d = fa_q;
        fw_d = fw_q;
        fu_d = fu_q;
        case (cap_q)
            SETM_CAP_IDLE: begin
                if (ahb_evt) begin
                    fa_d = ahb_err_addr;
                    fw_d = ahb_err_write;
                    fu_d = ahb_ue_evt;
                    cap_d = SETM_CAP_HELD;
                end
            end
            SETM_CAP_HELD: begin
                // rearm; an error in the clear cycle is captured at once
                if (ahb_status_clr) begin
                    cap_d = ahb_evt ? SETM_CAP_HELD : SETM_CAP_IDLE;
                    if (ahb_evt) begin
                        fa_d = ahb_err_addr;
                        fw_d = ahb_err_write;
                        fu_d = ahb_ue_evt;
                    end
                end
            end
            default: cap_d = SETM_CAP_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cap_q <= SETM_CAP_IDLE;
            fa_q <= '0;
            fw_q <= 1'b0;
            fu_q <= 1'b0;
        end else begin
            cap_q <= cap_d;
            fa_q <= fa_d;
            fw_q <= fw_d;
            fu_q <= fu_d;
        end
    end

    // interrupt from enabled, latched threshold conditions
    logic irq_q, irq_d;
    always_comb begin
        irq_d = irq_en_q && (|(st_q & en_q));
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // outputs
    assign ahb_fail_addr = fa_q;
    assign ahb_fail_write = fw_q;
    assign ahb_fail_ue = fu_q;
    assign ahb_ce_status = st_q[`SETM_IDX_CE];
    assign ahb_ue_status = st_q[`SETM_IDX_UE];
    assign scrub_run_status = st_q[`SETM_IDX_RUN];
    assign scrub_blk_status = st_q[`SETM_IDX_BLK];
    assign ahb_ce_count = cnt[`SETM_IDX_CE];
    assign ahb_ue_count = cnt[`SETM_IDX_UE];
    assign scrub_run_count = cnt[`SETM_IDX_RUN];
    assign scrub_blk_count = cnt[`SETM_IDX_BLK];
    assign thr_en = en_q;
    assign irq_en = irq_en_q;
    assign ue_thr = ue_thr_q;
    assign ce_thr = ce_thr_q;
    assign blk_thr = blk_thr_q;
    assign run_thr = run_thr_q;
    assign err_irq = irq_q;

    // checks
    disabled_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        !en_q[0] |=> !st_q[0]) else $error("disabled ce type raised status");
    // the other three types stay quiet when disabled too
    ue_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        !en_q[1] |=> !st_q[1]) else $error("disabled ue type raised status");
    run_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        !en_q[2] |=> !st_q[2]) else $error("disabled run type raised status");
    blk_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        !en_q[3] |=> !st_q[3]) else $error("disabled blk type raised status");
    // every enabled type sets status one cycle after its count passes the threshold
    ce_over_a: assert property (@(posedge mclk) disable iff (!rstn)
        (en_q[0] && cnt[0] > ce_thr_q && !clr[0] && en_d[0]) |=> st_q[0]) else $error("ce over without status");
    run_over_a: assert property (@(posedge mclk) disable iff (!rstn)
        (en_q[2] && cnt[2] > run_thr_q && !clr[2] && en_d[2]) |=> st_q[2]) else $error("run over without status");
    blk_over_a: assert property (@(posedge mclk) disable iff (!rstn)
        (en_q[3] && cnt[3] > {2'h0, blk_thr_q} && !clr[3] && en_d[3]) |=> st_q[3])
        else $error("blk over without status");
    over_sets_a: assert property (@(posedge mclk) disable iff (!rstn)
        (en_q[1] && cnt[1] > {2'h0, ue_thr_q} && !clr[1] && en_d[1]) |=> st_q[1])
        else $error("ue over threshold without status");
    ue_width_a: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_ahb_we |=> ue_thr_q == $past(ue_thr_wr[7:0])) else $error("ue threshold not low eight bits");
    ce_width_a: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_ahb_we |=> ce_thr_q == $past(ce_thr_wr[9:0])) else $error("ce threshold not low ten bits");
    blk_width_a: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_scrub_we |=> blk_thr_q == $past(blk_thr_wr[7:0])) else $error("blk threshold wrong");
    run_width_a: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_scrub_we |=> run_thr_q == $past(run_thr_wr[9:0])) else $error("run threshold wrong");
    enable_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!cfg_ahb_we && !cfg_scrub_we) |=> en_q == $past(en_q)) else $error("enable changed without write");
    capture_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cap_q == SETM_CAP_HELD && !ahb_status_clr) |=> fa_q == $past(fa_q)) else $error("capture overwritten");
    clear_rearm_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ahb_status_clr && !ahb_evt) |=> cap_q == SETM_CAP_IDLE && ahb_ce_count == '0)
        else $error("no rearm after clear");
    irq_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        err_irq |-> $past(irq_en_q) && $past(|(st_q & en_q))) else $error("irq without enabled cause");
    irq_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
        (irq_en_q && |(st_q & en_q)) |=> err_irq) else $error("enabled cause without irq");
    // counters step by one per error and keep an error that meets a clear
    count_step_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ahb_ce_evt && !ahb_status_clr && cnt[0] != {CNT_W{1'b1}}) |=> cnt[0] == $past(cnt[0]) + 1'b1)
        else $error("ce counter did not step");
    clear_event_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ahb_status_clr && ahb_ce_evt) |=> ahb_ce_count == CNT_W'(1))
        else $error("error in clear cycle lost");
    count_sat_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cnt[2] == {CNT_W{1'b1}} && !clr[2]) |=> cnt[2] == {CNT_W{1'b1}}) else $error("run counter wrapped");
    irq_seen_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(err_irq));
    ue_status_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(ahb_ue_status));
    blk_clear_c: cover property (@(posedge mclk) disable iff (!rstn) scrub_blk_status ##1 !scrub_blk_status);
    clr_evt_c: cover property (@(posedge mclk) disable iff (!rstn) ahb_status_clr && ahb_ce_evt);
endmodule // setm_monitor
`default_nettype wire

// ==== setm_params.svh ====
// timing-free constants for the scrub error threshold monitor
`ifndef SETM_PARAMS_SVH
`define SETM_PARAMS_SVH
`define SETM_UE_THR_W 8
`define SETM_CE_THR_W 10
`define SETM_BLK_THR_W 8
`define SETM_RUN_THR_W 10
`define SETM_CNT_W 10
`define SETM_ADDR_W 32
`define SETM_EN_RESET 1'b0
`define SETM_CNT_RESET 10'h000
`define SETM_IDX_CE 0
`define SETM_IDX_UE 1
`define SETM_IDX_RUN 2
`define SETM_IDX_BLK 3
`endif

// ==== setm_partner.sv ====
// far-side model: ahb error reporter and scrubber error reporter
`default_nettype none
module setm_partner (
    // clock
    input wire logic mclk,
    // ahb access error reports
    output logic ahb_ce_evt,
    output logic ahb_ue_evt,
    output logic [31:0] ahb_err_addr,
    output logic ahb_err_write,
    // scrubber error reports
    output logic scrub_run_evt,
    output logic scrub_blk_evt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] evt = 4'h0;
    // one pulse bit per error type: 0 ce, 1 ue, 2 run, 3 blk
    assign {scrub_blk_evt, scrub_run_evt, ahb_ue_evt, ahb_ce_evt} = evt;
    // access info idles at zero before the first report
    initial begin
        ahb_err_addr = 32'h0;
        ahb_err_write = 1'b0;
    end
    // report one error as a single-cycle pulse
    task automatic send(input int idx, input logic [31:0] addr, input logic wr);
        @(posedge mclk);
        #1;
        evt[idx] = 1'b1;
        ahb_err_addr = addr;
        ahb_err_write = wr;
        @(posedge mclk);
        #1;
        evt = 4'h0;
        // access info is invalid now, so show the inverse instead of a stale copy
        ahb_err_addr = ~addr;
        ahb_err_write = ~wr;
    endtask
endmodule // setm_partner
`default_nettype wire

// ==== setm_pkg.sv ====
// types shared by the scrub error threshold monitor
`default_nettype none
package setm_pkg;
    typedef enum logic [1:0] {
        SETM_CAP_IDLE = 2'b01,
        SETM_CAP_HELD = 2'b10
    } setm_cap_state_type;
endpackage
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the scrub error threshold monitor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import setm_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ahb_ce_evt, ahb_ue_evt, ahb_err_write, scrub_run_evt, scrub_blk_evt;
    logic [31:0] ahb_err_addr, ahb_fail_addr;
    logic [31:0] ue_thr_wr = 32'h0, ce_thr_wr = 32'h0, blk_thr_wr = 32'h0, run_thr_wr = 32'h0;
    logic cfg_ahb_we = 1'b0, cfg_scrub_we = 1'b0, irq_en_wr = 1'b0, irq_en_we = 1'b0;
    logic ce_en_wr = 1'b0, ue_en_wr = 1'b0, run_en_wr = 1'b0, blk_en_wr = 1'b0;
    logic ahb_status_clr = 1'b0, scrub_status_clr = 1'b0;
    logic ahb_fail_write, ahb_fail_ue, ahb_ce_status, ahb_ue_status, scrub_run_status, scrub_blk_status;
    logic [9:0] ahb_ce_count, ahb_ue_count, scrub_run_count, scrub_blk_count, ce_thr, run_thr;
    logic [7:0] ue_thr, blk_thr;
    logic [3:0] thr_en;
    logic irq_en, err_irq;
    logic [3:0] st;
    logic [9:0] cnt [4];
    int n_mismatch = 0;
    int total_checks = 0;
    // status and counts indexed by error type: 0 ce, 1 ue, 2 run, 3 blk
    assign st = {scrub_blk_status, scrub_run_status, ahb_ue_status, ahb_ce_status};
    assign cnt[0] = ahb_ce_count;
    assign cnt[1] = ahb_ue_count;
    assign cnt[2] = scrub_run_count;
    assign cnt[3] = scrub_blk_count;
    always #2 mclk = ~mclk;
    setm_monitor dut_u (.mclk, .rstn, .ahb_ce_evt, .ahb_ue_evt, .ahb_err_addr, .ahb_err_write, .scrub_run_evt,
        .scrub_blk_evt, .ue_thr_wr, .ce_thr_wr, .blk_thr_wr, .run_thr_wr, .cfg_ahb_we, .cfg_scrub_we, .ce_en_wr,
        .ue_en_wr, .run_en_wr, .blk_en_wr, .irq_en_wr, .irq_en_we, .ahb_status_clr, .scrub_status_clr,
        .ahb_fail_addr, .ahb_fail_write, .ahb_fail_ue, .ahb_ce_status, .ahb_ue_status, .ahb_ce_count,
        .ahb_ue_count, .scrub_run_status, .scrub_blk_status, .scrub_run_count, .scrub_blk_count, .thr_en,
        .irq_en, .ue_thr, .ce_thr, .blk_thr, .run_thr, .err_irq);
    setm_partner partner_u (.mclk, .ahb_ce_evt, .ahb_ue_evt, .ahb_err_addr, .ahb_err_write, .scrub_run_evt,
        .scrub_blk_evt);
    // inputs always move 1 ns after the rising edge, never on it
    task automatic step(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic chk_v(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_b(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // same threshold word to all four fields, so the width cut is visible per field
    task automatic cfg(input logic [31:0] thr, input logic [3:0] en, input logic ie);
        {ue_thr_wr, ce_thr_wr, blk_thr_wr, run_thr_wr} = {4{thr}};
        {blk_en_wr, run_en_wr, ue_en_wr, ce_en_wr} = en;
        irq_en_wr = ie;
        {cfg_ahb_we, cfg_scrub_we, irq_en_we} = 3'b111;
        step(1);
        {cfg_ahb_we, cfg_scrub_we, irq_en_we} = 3'b000;
    endtask
    // trailing idle cycle keeps two clears from touching one strobe in one time step
    task automatic clr(input logic scrub);
        if (scrub) begin
            scrub_status_clr = 1'b1;
        end else begin
            ahb_status_clr = 1'b1;
        end
        step(1);
        {scrub_status_clr, ahb_status_clr} = 2'b00;
        step(1);
    endtask
    task automatic t_reset;
        chk_v("thr_en", 32'h0, thr_en);
        chk_b("irq_en", 1'b0, irq_en);
        chk_v("status", 32'h0, st);
        chk_b("err_irq", 1'b0, err_irq);
        $display("test reset done");
    endtask
    task automatic t_capture;
        partner_u.send(1, 32'h0000_a5a4, 1'b1);
        chk_v("fail addr", 32'h0000_a5a4, ahb_fail_addr);
        chk_b("fail write", 1'b1, ahb_fail_write);
        chk_b("fail ue", 1'b1, ahb_fail_ue);
        partner_u.send(0, 32'h0000_5a58, 1'b0);
        chk_v("held addr", 32'h0000_a5a4, ahb_fail_addr);
        clr(1'b0);
        partner_u.send(0, 32'h0000_5a58, 1'b0);
        chk_v("rearmed addr", 32'h0000_5a58, ahb_fail_addr);
        chk_b("rearmed ue", 1'b0, ahb_fail_ue);
        chk_b("rearmed write", 1'b0, ahb_fail_write);
        clr(1'b0);
        $display("test capture done");
    endtask
    task automatic t_width;
        cfg(32'hffff_fd05, 4'hf, 1'b0);
        chk_v("ue_thr", 32'h05, ue_thr);
        chk_v("ce_thr", 32'h105, ce_thr);
        chk_v("blk_thr", 32'h05, blk_thr);
        chk_v("run_thr", 32'h105, run_thr);
        chk_v("thr_en", 32'hf, thr_en);
        repeat (5) partner_u.send(1, 32'h0, 1'b0);
        step(2);
        chk_b("ue at threshold", 1'b0, ahb_ue_status);
        partner_u.send(1, 32'h0, 1'b0);
        step(2);
        chk_b("ue over threshold", 1'b1, ahb_ue_status);
        chk_b("irq masked", 1'b0, err_irq);
        cfg(32'hffff_fd05, 4'hf, 1'b1);
        step(2);
        chk_b("irq unmasked", 1'b1, err_irq);
        chk_b("irq_en set", 1'b1, irq_en);
        cfg(32'hffff_fd05, 4'hd, 1'b1);
        step(2);
        chk_b("ue disabled", 1'b0, ahb_ue_status);
        chk_b("irq disabled", 1'b0, err_irq);
        clr(1'b0);
        $display("test width done");
    endtask
    task automatic t_disabled;
        cfg(32'h0, 4'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            repeat (2) partner_u.send(i, 32'h0000_0400, 1'b1);
            step(3);
            chk_v("count disabled", 32'h2, cnt[i]);
        end
        chk_v("status disabled", 32'h0, st);
        chk_b("irq disabled", 1'b0, err_irq);
        clr(1'b0);
        clr(1'b1);
        $display("test disabled done");
    endtask
    // threshold 2 per type: two errors stay quiet, the third trips status and interrupt
    task automatic t_thresh(input int i);
        cfg(32'h2, 4'h1 << i, 1'b1);
        repeat (2) partner_u.send(i, 32'h0000_0100, 1'b0);
        step(3);
        chk_v("count", 32'h2, cnt[i]);
        chk_b("status at threshold", 1'b0, st[i]);
        chk_b("irq at threshold", 1'b0, err_irq);
        partner_u.send(i, 32'h0000_0104, 1'b0);
        step(2);
        chk_b("status over", 1'b1, st[i]);
        chk_b("irq over", 1'b1, err_irq);
        clr(i >= 2);
        step(1);
        chk_b("status cleared", 1'b0, st[i]);
        chk_v("count cleared", 32'h0, cnt[i]);
        chk_b("irq cleared", 1'b0, err_irq);
        repeat (3) partner_u.send(i, 32'h0000_0108, 1'b0);
        step(2);
        chk_b("status rearmed", 1'b1, st[i]);
        clr(i >= 2);
        $display("test threshold %0d done", i);
    endtask
    // run counter saturates at 1023; a clear meeting an error keeps that error and recaptures the access
    task automatic t_edge;
        repeat (1025) partner_u.send(2, 32'h0, 1'b0);
        step(1);
        chk_v("run count saturated", 32'h3ff, scrub_run_count);
        partner_u.send(1, 32'h0000_0a0a, 1'b0);
        fork
            partner_u.send(0, 32'h0000_0c0c, 1'b1);
            begin
                step(1);
                ahb_status_clr = 1'b1;
                step(1);
                ahb_status_clr = 1'b0;
            end
        join
        step(1);
        chk_v("count after clear with error", 32'h1, ahb_ce_count);
        chk_v("recaptured addr", 32'h0000_0c0c, ahb_fail_addr);
        chk_b("recaptured ue", 1'b0, ahb_fail_ue);
        chk_v("ue count cleared", 32'h0, ahb_ue_count);
        clr(1'b0);
        clr(1'b1);
        chk_v("run count cleared", 32'h0, scrub_run_count);
        $display("test edge done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rstn = 1'b1;
        step(1);
        t_reset();
        t_capture();
        t_width();
        t_disabled();
        for (int i = 0; i < 4; i++) t_thresh(i);
        t_edge();
        end_of_test();
    end
    // watchdog: the tests need about 2240 cycles, the saturation run being most of them
    initial begin
        #80000;
        n_mismatch++;
        $display("mismatch watchdog expected done seen timeout");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
